// ===== core/sm_pkg.sv
// Shared constants and types for the shift, move and indirect-load datapath
package sm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int MEM_AW = 8;
  localparam int PTR_W  = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CMD_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] WREG_OFS     = 12'h008;
  localparam logic [11:0] PTR0_OFS     = 12'h00C;
  localparam logic [11:0] PTR1_OFS     = 12'h010;
  localparam logic [11:0] MEM_BASE_OFS = 12'h400;
  localparam logic [11:0] MEM_END_OFS  = 12'h7FC;

  // ----------------------------------------------------------------
  // Command field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;
  localparam int CMD_DEST_BIT = 2;
  localparam int CMD_FA_LSB   = 3;
  localparam int CMD_PSEL_BIT = 10;
  localparam int CMD_MODE_LSB = 11;
  localparam int CMD_REL_BIT  = 13;
  localparam int CMD_OFS_LSB  = 14;

  // Status field positions
  localparam int ST_C_BIT    = 0;
  localparam int ST_Z_BIT    = 1;
  localparam int ST_BUSY_BIT = 2;

  // File addresses that stand for the indirect data port of each pointer
  localparam logic [6:0] INDIRECT_PORT0_FA = 7'h00;
  localparam logic [6:0] INDIRECT_PORT1_FA = 7'h01;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]       WREG_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NONE                   = 2'h0,
    OP_LOGICAL_SHIFT_RIGHT_OP = 2'h1,
    OP_MOVE_FILE_OP           = 2'h2,
    OP_INDIRECT_LOAD_OP       = 2'h3
  } op_t;

  typedef enum logic [1:0] {
    MODE_PRE_INC  = 2'h0,
    MODE_PRE_DEC  = 2'h1,
    MODE_POST_INC = 2'h2,
    MODE_POST_DEC = 2'h3
  } addr_mode_field_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_EXEC = 2'h3
  } exec_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0]       offset;
    logic             relative;
    addr_mode_field_t mode;
    logic             ptr_sel;
    logic [6:0]       file_addr;
    logic             dest;
    op_t              op;
  } cmd_t;

  typedef struct packed {
    logic              we;
    logic [MEM_AW-1:0] addr;
    logic [7:0]        wdata;
  } mem_req_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_zero8(input logic [7:0] v);
    return v == 8'h00;
  endfunction

endpackage

// ===== core/data_mem.sv
// Byte-wide data memory with a registered read port
`timescale 1ns/10ps

module data_mem (
  input  wire logic              pclk,
  input  wire sm_pkg::mem_req_t  req,
  output logic [7:0]             rdata
);

  logic [7:0] mem_array [0:(1 << sm_pkg::MEM_AW)-1];

  always_ff @(posedge pclk) begin
    if (req.we) begin
      mem_array[req.addr] <= req.wdata;
    end
    rdata <= mem_array[req.addr];
  end

endmodule

// ===== core/pointer_unit.sv
// Effective address and updated value of a file select pointer
`timescale 1ns/10ps

module pointer_unit (
  input  wire logic [15:0]              ptr,
  input  wire sm_pkg::addr_mode_field_t mode,
  input  wire logic                     relative,
  input  wire logic [5:0]               offset,
  output logic [15:0]                   eff_addr,
  output logic [15:0]                   ptr_next
);

  logic [15:0] ptr_inc;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_rel;

  always_comb begin
    // Wraps modulo 2^16 by width
    ptr_inc = ptr + 16'h0001;
    ptr_dec = ptr - 16'h0001;
    ptr_rel = ptr + {{10{offset[5]}}, offset};
    if (relative) begin
      eff_addr = ptr_rel;
      ptr_next = ptr;
    end else begin
      unique case (mode)
        sm_pkg::MODE_PRE_INC: begin
          eff_addr = ptr_inc;
          ptr_next = ptr_inc;
        end
        sm_pkg::MODE_PRE_DEC: begin
          eff_addr = ptr_dec;
          ptr_next = ptr_dec;
        end
        sm_pkg::MODE_POST_INC: begin
          eff_addr = ptr;
          ptr_next = ptr_inc;
        end
        sm_pkg::MODE_POST_DEC: begin
          eff_addr = ptr;
          ptr_next = ptr_dec;
        end
      endcase
    end
  end

endmodule

// ===== core/shift_move_indirect_exec.sv
// Shift, move and indirect-load execution datapath behind an APB slave
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps

module shift_move_indirect_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    sm_pkg::exec_state_t st;
    sm_pkg::cmd_t        cmd;
    logic [7:0]          w;
    logic                c;
    logic                z;
    logic [15:0]         ptr0;
    logic [15:0]         ptr1;
    logic                phase;
    logic                pready;
    logic                pslverr;
    logic [31:0]         prdata;
  } state_t;

  localparam state_t STATE_RST = '{
    st:      sm_pkg::ST_IDLE,
    cmd:     '0,
    w:       sm_pkg::WREG_RST,
    c:       1'b0,
    z:       1'b0,
    ptr0:    sm_pkg::PTR_RST,
    ptr1:    sm_pkg::PTR_RST,
    phase:   1'b0,
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  32'h0000_0000
  };

  state_t s_reg;
  state_t s_next;

  // ----------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------
  sm_pkg::mem_req_t mem_req;
  logic [7:0]       mem_rdata;
  logic [15:0]      sel_ptr;
  logic [15:0]      ind_addr;
  logic [15:0]      ptr_upd;
  logic [7:0]       exec_addr;
  logic             is_port;
  logic             is_port0;
  logic             is_port1;
  logic             port_sel;
  logic [7:0]       result;
  logic             mem_hit;
  logic             reg_hit;
  logic             apb_access;
  logic             apb_commit;
  logic             reg_wr;
  logic             busy;

  function automatic logic [7:0] file_to_mem(input logic [6:0] fa);
    return {1'b0, fa};
  endfunction

  // Zero extension of byte and pointer values to the bus width
  function automatic logic [31:0] zext8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  // Engine owns the memory port and the state while busy
  assign busy = s_reg.st != sm_pkg::ST_IDLE;

  // ----------------------------------------------------------------
  // Indirect port and pointer selection
  // ----------------------------------------------------------------
  // Indirect data port of pointer 0 or 1 has no storage
  assign is_port0 = s_reg.cmd.file_addr == sm_pkg::INDIRECT_PORT0_FA;
  assign is_port1 = s_reg.cmd.file_addr == sm_pkg::INDIRECT_PORT1_FA;
  assign is_port  = is_port0 || is_port1;
  assign port_sel = (s_reg.cmd.op == sm_pkg::OP_INDIRECT_LOAD_OP) ? s_reg.cmd.ptr_sel
                  : is_port1;
  assign sel_ptr  = port_sel ? s_reg.ptr1 : s_reg.ptr0;

  pointer_unit u_pointer_unit (
    .ptr      (sel_ptr),
    .mode     (s_reg.cmd.mode),
    .relative (s_reg.cmd.relative),
    .offset   (s_reg.cmd.offset),
    .eff_addr (ind_addr),
    .ptr_next (ptr_upd)
  );

  // ----------------------------------------------------------------
  // Execution address and result
  // ----------------------------------------------------------------
  always_comb begin
    if (s_reg.cmd.op == sm_pkg::OP_INDIRECT_LOAD_OP) begin
      exec_addr = ind_addr[7:0];
    end else if (is_port) begin
      exec_addr = sel_ptr[7:0];
    end else begin
      exec_addr = file_to_mem(s_reg.cmd.file_addr);
    end
  end

  always_comb begin
    unique case (s_reg.cmd.op)
      sm_pkg::OP_LOGICAL_SHIFT_RIGHT_OP: begin
        result = {1'b0, mem_rdata[7:1]};
      end
      default: begin
        result = mem_rdata;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign mem_hit    = (paddr >= sm_pkg::MEM_BASE_OFS) && (paddr <= sm_pkg::MEM_END_OFS)
                    && (paddr[1:0] == 2'h0);
  assign reg_hit    = (paddr == sm_pkg::CMD_OFS) || (paddr == sm_pkg::STATUS_OFS)
                    || (paddr == sm_pkg::WREG_OFS) || (paddr == sm_pkg::PTR0_OFS)
                    || (paddr == sm_pkg::PTR1_OFS);
  assign apb_access = psel && penable && !s_reg.pready;
  assign apb_commit = psel && penable && s_reg.pready;
  assign reg_wr     = apb_commit && pwrite && !s_reg.pslverr && !busy;

  // ----------------------------------------------------------------
  // Memory port: engine owns it while busy, APB only when idle
  // ----------------------------------------------------------------
  always_comb begin
    mem_req.we    = 1'b0;
    mem_req.addr  = exec_addr;
    mem_req.wdata = result;
    if (s_reg.st == sm_pkg::ST_EXEC) begin
      mem_req.we = s_reg.cmd.dest && (s_reg.cmd.op != sm_pkg::OP_INDIRECT_LOAD_OP);
    end else if (!busy) begin
      mem_req.addr  = paddr[9:2];
      mem_req.wdata = pwdata[7:0];
      mem_req.we    = apb_commit && pwrite && mem_hit && !s_reg.pslverr;
    end
  end

  data_mem u_data_mem (
    .pclk  (pclk),
    .req   (mem_req),
    .rdata (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // APB access: waits while busy, one read-settle cycle, then ready
    if (apb_commit) begin
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
      s_next.prdata  = 32'h0000_0000;
    end else if (apb_access && !busy) begin
      if (!s_reg.phase) begin
        s_next.phase = 1'b1;
      end else begin
        s_next.phase   = 1'b0;
        s_next.pready  = 1'b1;
        s_next.pslverr = !(mem_hit || reg_hit);
        if (!pwrite) begin
          if (mem_hit) begin
            s_next.prdata = zext8(mem_rdata);
          end else if (paddr == sm_pkg::CMD_OFS) begin
            s_next.prdata = {12'h000, s_reg.cmd};
          end else if (paddr == sm_pkg::STATUS_OFS) begin
            s_next.prdata = {29'h0000_0000, busy, s_reg.z, s_reg.c};
          end else if (paddr == sm_pkg::WREG_OFS) begin
            s_next.prdata = zext8(s_reg.w);
          end else if (paddr == sm_pkg::PTR0_OFS) begin
            s_next.prdata = zext16(s_reg.ptr0);
          end else if (paddr == sm_pkg::PTR1_OFS) begin
            s_next.prdata = zext16(s_reg.ptr1);
          end
        end
      end
    end

    // Register writes take effect at the completing edge
    if (reg_wr) begin
      unique case (paddr)
        sm_pkg::CMD_OFS: begin
          s_next.cmd = sm_pkg::cmd_t'(pwdata[19:0]);
          if (sm_pkg::op_t'(pwdata[1:0]) != sm_pkg::OP_NONE) begin
            s_next.st = sm_pkg::ST_READ;
          end
        end
        sm_pkg::STATUS_OFS: begin
          s_next.c = pwdata[sm_pkg::ST_C_BIT];
          s_next.z = pwdata[sm_pkg::ST_Z_BIT];
        end
        sm_pkg::WREG_OFS: begin
          s_next.w = pwdata[7:0];
        end
        sm_pkg::PTR0_OFS: begin
          s_next.ptr0 = pwdata[15:0];
        end
        sm_pkg::PTR1_OFS: begin
          s_next.ptr1 = pwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // Execution engine
    unique case (s_reg.st)
      sm_pkg::ST_IDLE: begin
      end
      sm_pkg::ST_READ: begin
        s_next.st = sm_pkg::ST_EXEC;
      end
      sm_pkg::ST_EXEC: begin
        s_next.st = sm_pkg::ST_IDLE;
        unique case (s_reg.cmd.op)
          sm_pkg::OP_LOGICAL_SHIFT_RIGHT_OP: begin
            s_next.c = mem_rdata[0];
            s_next.z = sm_pkg::is_zero8(result);
            if (!s_reg.cmd.dest) begin
              s_next.w = result;
            end
          end
          sm_pkg::OP_MOVE_FILE_OP: begin
            s_next.z = sm_pkg::is_zero8(result);
            if (!s_reg.cmd.dest) begin
              s_next.w = result;
            end
          end
          sm_pkg::OP_INDIRECT_LOAD_OP: begin
            s_next.w = mem_rdata;
            s_next.z = sm_pkg::is_zero8(mem_rdata);
            if (s_reg.cmd.ptr_sel) begin
              s_next.ptr1 = ptr_upd;
            end else begin
              s_next.ptr0 = ptr_upd;
            end
          end
          sm_pkg::OP_NONE: begin
          end
        endcase
      end
      default: begin
        s_next.st = sm_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pready  = s_reg.pready;
  assign prdata  = s_reg.prdata;
  assign pslverr = s_reg.pslverr;

endmodule

// ===== sim/shift_move_indirect_exec_asserts.sv
// Port checks for the shift, move and indirect-load datapath
`timescale 1ns/10ps

module shift_move_indirect_exec_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic mapped;
  logic rd_ptr;
  logic rd_byte;
  assign mapped  = (paddr inside {sm_pkg::CMD_OFS, sm_pkg::STATUS_OFS, sm_pkg::WREG_OFS, sm_pkg::PTR0_OFS,
                   sm_pkg::PTR1_OFS}) || (paddr[11:10] == 2'h1 && paddr[1:0] == 2'h0);
  assign rd_ptr  = pready && !pwrite && (paddr == sm_pkg::PTR0_OFS || paddr == sm_pkg::PTR1_OFS);
  assign rd_byte = pready && !pwrite && mapped && (paddr == sm_pkg::WREG_OFS || paddr[11:10] == 2'h1);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence

  a_answer_window: assert property (s_setup |=> !pready [*2] ##[1:3] s_done)
    else $error("pready outside its window after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr without pready or with data");
  a_unmapped_err: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  a_ptr_width: assert property (rd_ptr |-> prdata[31:16] == 16'h0)
    else $error("pointer read wider than sixteen bits");
  a_byte_width: assert property (rd_byte |-> prdata[31:8] == 24'h0)
    else $error("byte register read wider than eight bits");
endmodule

bind shift_move_indirect_exec shift_move_indirect_exec_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

// ===== sim/apb_host.sv
// Behavioural APB host issuing one transfer at a time
`timescale 1ns/10ps

module apb_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic tmo);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    tmo = (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
endmodule

// ===== sim/shift_move_indirect_exec_bench.sv
// Self-checking bench for the shift, move and indirect-load datapath
`timescale 1ns/10ps

module shift_move_indirect_exec_bench;
  localparam logic [11:0] A_W  = sm_pkg::WREG_OFS;
  localparam logic [11:0] A_ST = sm_pkg::STATUS_OFS;
  localparam logic [11:0] A_P0 = sm_pkg::PTR0_OFS;
  localparam logic [11:0] A_P1 = sm_pkg::PTR1_OFS;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  int          n_errors;
  int          checks_done;

  initial pclk = 1'h0;
  always #2.5 pclk = ~pclk;

  apb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  shift_move_indirect_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

  task automatic stop_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    logic tmo;
    u_host.xfer(w, a, d, q, e, tmo);
    if (tmo) begin
      n_errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(1'h1, a, d, q, e);
  endtask

  task automatic rc(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    xfer(1'h0, a, 32'h0, q, e);
    check(name, q, exp);
  endtask

  function automatic logic [11:0] ma(input logic [7:0] a);
    return sm_pkg::MEM_BASE_OFS + {2'h0, a, 2'h0};
  endfunction

  task automatic run(input logic [1:0] op, input logic dst, input logic [6:0] fa, input logic ps,
                     input logic [1:0] mode, input logic rel, input logic [5:0] ofs);
    sm_pkg::cmd_t c;
    c = '{offset: ofs, relative: rel, mode: sm_pkg::addr_mode_field_t'(mode), ptr_sel: ps,
          file_addr: fa, dest: dst, op: sm_pkg::op_t'(op)};
    wr(sm_pkg::CMD_OFS, {12'h000, c});
  endtask

  task automatic t_reset;
    logic [31:0] q;
    logic        e;
    rc("w", A_W, 32'h0);
    rc("status", A_ST, 32'h0);
    rc("ptr0", A_P0, 32'h0);
    rc("ptr1", A_P1, 32'h0);
    rc("cmd", sm_pkg::CMD_OFS, 32'h0);
    xfer(1'h0, 12'h014, 32'h0, q, e);
    check("unmapped err", {31'h0, e}, 32'h1);
    xfer(1'h1, 12'h402, 32'hFF, q, e);
    check("unaligned err", {31'h0, e}, 32'h1);
  endtask

  task automatic t_shift_move;
    wr(ma(8'h23), 32'h81);
    run(2'h1, 1'h0, 7'h23, 1'h0, 2'h0, 1'h0, 6'h00);
    rc("shift w", A_W, 32'h40);
    rc("shift flags", A_ST, 32'h1);
    rc("shift src", ma(8'h23), 32'h81);
    wr(ma(8'h24), 32'h01);
    run(2'h1, 1'h1, 7'h24, 1'h0, 2'h0, 1'h0, 6'h00);
    rc("shift file", ma(8'h24), 32'h00);
    rc("shift zero", A_ST, 32'h3);
    rc("shift w kept", A_W, 32'h40);
    wr(A_W, 32'h55);
    wr(ma(8'h7F), 32'h00);
    run(2'h2, 1'h0, 7'h7F, 1'h0, 2'h0, 1'h0, 6'h00);
    rc("move w", A_W, 32'h00);
    rc("move zero", A_ST, 32'h3);
    wr(ma(8'h10), 32'h3C);
    run(2'h2, 1'h1, 7'h10, 1'h0, 2'h0, 1'h0, 6'h00);
    rc("move file", ma(8'h10), 32'h3C);
    rc("move test", A_ST, 32'h1);
    rc("move w kept", A_W, 32'h0);
  endtask

  task automatic t_modes;
    logic [15:0] p;
    logic [15:0] pn;
    logic [15:0] ea;
    logic [31:0] v;
    wr(ma(8'h00), 32'h00);
    wr(ma(8'hFF), 32'h9A);
    for (int m = 0; m < 4; m++) begin
      p = m[0] ? 16'h0000 : 16'hFFFF;
      pn = m[0] ? p - 16'h1 : p + 16'h1;
      ea = m[1] ? p : pn;
      v = (ea[7:0] == 8'h00) ? 32'h00 : 32'h9A;
      wr(m[1] ? A_P1 : A_P0, {16'h0, p});
      run(2'h3, 1'h0, 7'h00, m[1], m[1:0], 1'h0, 6'h00);
      rc("load w", A_W, v);
      rc("load ptr", m[1] ? A_P1 : A_P0, {16'h0, pn});
      rc("load flags", A_ST, {30'h0, v == 32'h0, 1'h1});
    end
  endtask

  task automatic t_rel_port;
    wr(A_P1, 32'h0040);
    wr(ma(8'h20), 32'h11);
    wr(ma(8'h5F), 32'h00);
    run(2'h3, 1'h0, 7'h00, 1'h1, 2'h2, 1'h1, 6'h20);
    rc("rel low w", A_W, 32'h11);
    rc("rel low flags", A_ST, 32'h1);
    run(2'h3, 1'h0, 7'h00, 1'h1, 2'h2, 1'h1, 6'h1F);
    rc("rel high w", A_W, 32'h00);
    rc("rel ptr", A_P1, 32'h0040);
    wr(A_P1, 32'h0150);
    wr(ma(8'h50), 32'h06);
    wr(A_ST, 32'h0);
    run(2'h1, 1'h1, 7'h01, 1'h0, 2'h0, 1'h0, 6'h00);
    rc("port mem", ma(8'h50), 32'h03);
    rc("port flags", A_ST, 32'h0);
    rc("port ptr", A_P1, 32'h0150);
    wr(A_P0, 32'hFF51);
    wr(ma(8'h51), 32'h7E);
    run(2'h2, 1'h0, 7'h00, 1'h0, 2'h0, 1'h0, 6'h00);
    rc("port0 w", A_W, 32'h7E);
    rc("port0 flags", A_ST, 32'h0);
  endtask

  task automatic t_mid_reset;
    wr(A_W, 32'hA5);
    run(2'h0, 1'h1, 7'h2A, 1'h1, 2'h3, 1'h1, 6'h15);
    rc("none cmd", sm_pkg::CMD_OFS, 32'h0005_7D54);
    rc("none w", A_W, 32'hA5);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    rc("reset w", A_W, 32'h0);
    rc("reset ptr0", A_P0, 32'h0);
    rc("reset cmd", sm_pkg::CMD_OFS, 32'h0);
  endtask

  initial begin
    n_errors = 0;
    checks_done = 0;
    presetn = 1'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_shift_move();
    t_modes();
    t_rel_port();
    t_mid_reset();
    stop_test();
  end
endmodule
